// ===== src/qbf_cfg.svh
// Purpose: Constants for the regulator fault interrupt logic.
// Assumes: 20 MHz device clock.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef QBF_CFG_SVH
`define QBF_CFG_SVH
`define QBF_CLK_MHZ 20
`define QBF_SHORT_DEB_US 20
`define QBF_LONG_DEB_US 1000
`define QBF_SHORT_DEB_CYC (`QBF_SHORT_DEB_US * `QBF_CLK_MHZ)
`define QBF_LONG_DEB_CYC (`QBF_LONG_DEB_US * `QBF_CLK_MHZ)
`define QBF_NUM_CORES 4
`define QBF_ILIM_W 3
`define QBF_ILIM_RST 3'h0
`endif

// ===== src/qbf_pkg.sv
// Purpose: Types for the regulator fault interrupt logic.
// Assumes: Nothing beyond the constants header.
// Notes: Core run state is the only enumeration.
package qbf_pkg;
    typedef enum logic [1:0] {
        QBF_CORE_OFF,
        QBF_CORE_START,
        QBF_CORE_RUN,
        QBF_CORE_TRIPPED
    } qbf_core_state_type;
endpackage : qbf_pkg

// ===== src/qbf_debounce.sv
// Purpose: Symmetric debounce filter with a sampling counter.
// Assumes: Input already synchronised to clk_in.
// Notes: The output follows the input once it has differed for CYCLES clocks.
`timescale 1ns/1ps
`default_nettype none
module qbf_debounce #(
    parameter int CYCLES = 400
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic raw_in,
    output var logic clean_out
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q;

    initial begin
        if (CYCLES < 1) begin
            $error("qbf_debounce CYCLES must be at least one");
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cnt_q <= '0;
            clean_out <= 1'b0;
        end else if (raw_in == clean_out) begin
            cnt_q <= '0;
        end else if (cnt_q == CW'(CYCLES - 1)) begin
            cnt_q <= '0;
            clean_out <= raw_in;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : qbf_debounce
`default_nettype wire

// ===== src/qbf_fault_irq.sv
// Function
// - Warnings only interrupt, protection disables cores, faults reset the device.
// - Any warning or protection event sets its flag; only unmasked flags pull interrupt low.
// - Interrupt stays low until every pending unmasked flag is cleared.
// - Shutdown faults show only as reset-occurred flag after next start-up.
// - Each per-core event sets the detailed flag and core summary bit.
// - Each core holds a 3-bit current limit; limiting keeps the core running.
// - Current limiting lasting 20 us sets the core current-limit flag only.
// - Live current-limit status per core, separate from the sticky flag.
// - Current-limit flag clears by write 1, ignored while limit is active.
// - Output under 0.35 V for 1 ms disables core and sets unmaskable short flag.
// - A short-circuit trip also drives the core running status to zero.
// - One bit selects warning threshold; warning sets flag, has live status.
// - Warning flag clears by write 1 unless still hot; it has a mask.
// - Thermal shutdown disables all cores, sets unmaskable flag with live status.
// - Power-good sets a maskable flag with live status; write 1 clears.
// - Load measurement done sets a maskable flag, no status; write 1 clears.
// - Start-up after reset pin rise sets maskable reset-occurred flag.
// - Supply glitch or software reset restarts with reset-occurred flag set.
// - Enables only synchronised; thermal, limit, good 20 us; overload 1 ms debounce.
// - After short flag clear a core retries start-up if still enabled.
//
// Purpose: Diagnosis and protection interrupt logic for four regulator cores.
// Assumes: Analog comparator levels arrive asynchronously; srst_in is the
//          power-on, reset pin, supply-lockout and software reset combined.
// Notes: Clear strobes are one-cycle pulses from the serial register logic.
`timescale 1ns/1ps
`default_nettype none
`include "qbf_cfg.svh"
module qbf_fault_irq
    import qbf_pkg::*;
#(
    parameter int NCORES = `QBF_NUM_CORES,
    parameter int SHORT_DEB_CYC = `QBF_SHORT_DEB_CYC,
    parameter int LONG_DEB_CYC = `QBF_LONG_DEB_CYC
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [NCORES-1:0] core_enable_in,
    input wire logic [NCORES*`QBF_ILIM_W-1:0] core_current_limit_sel_in,
    input wire logic [NCORES-1:0] core_ilimit_raw_in,
    input wire logic [NCORES-1:0] core_undervolt_raw_in,
    input wire logic [NCORES-1:0] core_pgood_raw_in,
    input wire logic overtemp_warn_raw_in,
    input wire logic overtemp_shutdown_raw_in,
    input wire logic overtemp_warn_threshold_sel_in,
    input wire logic load_meas_done_in,
    input wire logic [NCORES-1:0] core_ilimit_mask_in,
    input wire logic [NCORES-1:0] core_pgood_mask_in,
    input wire logic overtemp_warn_mask_in,
    input wire logic load_ready_mask_in,
    input wire logic reset_occurred_mask_in,
    input wire logic [NCORES-1:0] core_ilimit_clr_in,
    input wire logic [NCORES-1:0] core_short_clr_in,
    input wire logic [NCORES-1:0] core_pgood_clr_in,
    input wire logic overtemp_warn_clr_in,
    input wire logic overtemp_shutdown_clr_in,
    input wire logic load_ready_clr_in,
    input wire logic reset_occurred_clr_in,
    output logic irq_out_n,
    output logic [NCORES-1:0] core_irq_summary_out,
    output logic [NCORES-1:0] core_ilimit_flag_out,
    output logic [NCORES-1:0] core_ilimit_live_out,
    output logic [NCORES-1:0] core_short_flag_out,
    output logic [NCORES-1:0] core_running_status_out,
    output logic [NCORES-1:0] core_pgood_flag_out,
    output logic [NCORES-1:0] core_pgood_live_out,
    output logic overtemp_warn_flag_out,
    output logic overtemp_warn_live_out,
    output logic overtemp_shutdown_flag_out,
    output logic overtemp_shutdown_live_out,
    output logic load_ready_flag_out,
    output logic reset_occurred_flag_out,
    output logic [NCORES*`QBF_ILIM_W-1:0] core_current_limit_out,
    output logic overtemp_warn_threshold_out,
    output logic [NCORES-1:0] core_switch_en_out
);

    // ==========================================================
    // Elaboration checks
    initial begin
        if (NCORES < 1 || SHORT_DEB_CYC < 1 || LONG_DEB_CYC < SHORT_DEB_CYC) begin
            $error("qbf_fault_irq parameters out of range");
        end
    end

    // ==========================================================
    // Input synchronisers
    // Every comparator and pin passes two flops; only the second is read.
    localparam int NSYNC = 3 * NCORES + 3;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic [NCORES-1:0] en_s;
    logic [NCORES-1:0] ilim_s;
    logic [NCORES-1:0] uv_s;
    logic [NCORES-1:0] pg_s;
    logic warn_s;
    logic sd_s;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {core_enable_in, core_ilimit_raw_in, core_pgood_raw_in,
                        overtemp_warn_raw_in, overtemp_shutdown_raw_in,
                        overtemp_warn_threshold_sel_in};
            sync2_q <= sync1_q;
        end
    end

    // Enables are synchronised only, with no glitch filter.
    assign en_s = sync2_q[NSYNC-1 -: NCORES];

    // ==========================================================
    // Debounce filters
    // Undervoltage has a separate synchroniser chain since it is a longer filter.
    logic [NCORES-1:0] uv_sync1_q;
    logic [NCORES-1:0] uv_sync2_q;
    logic [NCORES-1:0] uv_arm;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            uv_sync1_q <= '0;
            uv_sync2_q <= '0;
        end else begin
            uv_sync1_q <= core_undervolt_raw_in;
            uv_sync2_q <= uv_sync1_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCORES; gi++) begin : g_deb
            qbf_debounce #(.CYCLES(SHORT_DEB_CYC)) u_ilim (
                .clk_in(clk_in),
                .srst_in(srst_in),
                .raw_in(sync2_q[NCORES + 3 + gi]),
                .clean_out(ilim_s[gi])
            );
            qbf_debounce #(.CYCLES(SHORT_DEB_CYC)) u_pg (
                .clk_in(clk_in),
                .srst_in(srst_in),
                .raw_in(sync2_q[3 + gi]),
                .clean_out(pg_s[gi])
            );
            // Held clear while the core is off, so the start-up window counts from enable.
            qbf_debounce #(.CYCLES(LONG_DEB_CYC)) u_uv (
                .clk_in(clk_in),
                .srst_in(srst_in || !uv_arm[gi]),
                .raw_in(uv_sync2_q[gi]),
                .clean_out(uv_s[gi])
            );
        end
    endgenerate

    qbf_debounce #(.CYCLES(SHORT_DEB_CYC)) u_warn (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .raw_in(sync2_q[2]),
        .clean_out(warn_s)
    );

    qbf_debounce #(.CYCLES(SHORT_DEB_CYC)) u_sd (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .raw_in(sync2_q[1]),
        .clean_out(sd_s)
    );

    // ==========================================================
    // Live status and configuration
    // Current limiting is only reported; the core keeps regulating at the limit.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_ilimit_live_out <= '0;
            core_pgood_live_out <= '0;
            overtemp_warn_live_out <= 1'b0;
            overtemp_shutdown_live_out <= 1'b0;
            overtemp_warn_threshold_out <= 1'b0;
            core_current_limit_out <= {NCORES{`QBF_ILIM_RST}};
        end else begin
            core_ilimit_live_out <= ilim_s;
            core_pgood_live_out <= pg_s;
            overtemp_warn_live_out <= warn_s;
            overtemp_shutdown_live_out <= sd_s;
            overtemp_warn_threshold_out <= sync2_q[0];
            core_current_limit_out <= core_current_limit_sel_in;
        end
    end

    // ==========================================================
    // Per-core run control
    qbf_core_state_type core_st_q [NCORES];
    logic [NCORES-1:0] ilim_d1_q;
    logic [NCORES-1:0] pg_d1_q;
    logic [NCORES-1:0] trip;

    generate
        for (gi = 0; gi < NCORES; gi++) begin : g_core
            // The 1 ms undervoltage filter runs only in START and RUN, so one trip
            // term serves both the start-up window and overload in operation.
            assign uv_arm[gi] = core_st_q[gi] == QBF_CORE_START ||
                                core_st_q[gi] == QBF_CORE_RUN;
            assign trip[gi] = uv_s[gi] && uv_arm[gi];

            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    core_st_q[gi] <= QBF_CORE_OFF;
                end else begin
                    unique case (core_st_q[gi])
                        QBF_CORE_OFF: begin
                            if (en_s[gi] && !sd_s && !overtemp_shutdown_flag_out) begin
                                core_st_q[gi] <= QBF_CORE_START;
                            end
                        end
                        QBF_CORE_START, QBF_CORE_RUN: begin
                            if (sd_s || !en_s[gi]) begin
                                core_st_q[gi] <= QBF_CORE_OFF;
                            end else if (trip[gi]) begin
                                core_st_q[gi] <= QBF_CORE_TRIPPED;
                            end else if (pg_s[gi]) begin
                                core_st_q[gi] <= QBF_CORE_RUN;
                            end
                        end
                        QBF_CORE_TRIPPED: begin
                            if (!core_short_flag_out[gi]) begin
                                core_st_q[gi] <= QBF_CORE_OFF;
                            end
                        end
                    endcase
                end
            end

            always_ff @(posedge clk_in) begin
                if (srst_in) begin
                    core_switch_en_out[gi] <= 1'b0;
                    core_running_status_out[gi] <= 1'b0;
                end else begin
                    core_switch_en_out[gi] <= (core_st_q[gi] == QBF_CORE_START ||
                                               core_st_q[gi] == QBF_CORE_RUN) &&
                                              !trip[gi] && !sd_s;
                    core_running_status_out[gi] <= core_st_q[gi] == QBF_CORE_RUN &&
                                                   !trip[gi];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Sticky flags
    // Set wins over clear; a clear is also refused while its source is active, except for power-good, which clears while still high.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ilim_d1_q <= '0;
            pg_d1_q <= '0;
        end else begin
            ilim_d1_q <= ilim_s;
            pg_d1_q <= pg_s;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_ilimit_flag_out <= '0;
        end else begin
            core_ilimit_flag_out <= (ilim_s & ~ilim_d1_q) | (core_ilimit_flag_out &
                                    ~(core_ilimit_clr_in & ~ilim_s));
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_short_flag_out <= '0;
        end else begin
            core_short_flag_out <= trip | (core_short_flag_out &
                                   ~core_short_clr_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_pgood_flag_out <= '0;
        end else begin
            core_pgood_flag_out <= (pg_s & ~pg_d1_q) | (core_pgood_flag_out &
                                   ~core_pgood_clr_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            overtemp_warn_flag_out <= 1'b0;
            overtemp_shutdown_flag_out <= 1'b0;
            load_ready_flag_out <= 1'b0;
        end else begin
            overtemp_warn_flag_out <= warn_s ||
                (overtemp_warn_flag_out && !overtemp_warn_clr_in);
            overtemp_shutdown_flag_out <= sd_s ||
                (overtemp_shutdown_flag_out && !overtemp_shutdown_clr_in);
            load_ready_flag_out <= load_meas_done_in ||
                (load_ready_flag_out && !load_ready_clr_in);
        end
    end

    // Every reset source ends here, so the flag is what reports a past fault.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reset_occurred_flag_out <= 1'b1;
        end else if (reset_occurred_clr_in) begin
            reset_occurred_flag_out <= 1'b0;
        end
    end

    // ==========================================================
    // Summary bits and interrupt line
    logic [NCORES-1:0] summary_d;
    logic irq_pending;

    assign summary_d = core_ilimit_flag_out | core_short_flag_out |
                       core_pgood_flag_out;

    assign irq_pending = |(core_ilimit_flag_out & ~core_ilimit_mask_in) ||
                         |core_short_flag_out ||
                         |(core_pgood_flag_out & ~core_pgood_mask_in) ||
                         (overtemp_warn_flag_out && !overtemp_warn_mask_in) ||
                         overtemp_shutdown_flag_out ||
                         (load_ready_flag_out && !load_ready_mask_in) ||
                         (reset_occurred_flag_out && !reset_occurred_mask_in);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            core_irq_summary_out <= '0;
            irq_out_n <= 1'b1;
        end else begin
            core_irq_summary_out <= summary_d;
            irq_out_n <= !irq_pending;
        end
    end

endmodule : qbf_fault_irq
`default_nettype wire

// ===== dv/qbf_host_model.sv
// Purpose: Host processor that services the interrupt line.
// Assumes: Flag and strobe vectors share the bench bit order.
// Notes: It writes 1 to every flag it sees, so refused clears get retried.
`timescale 1ns/1ps
`default_nettype none
module qbf_host_model (
    input wire logic clk_in,
    input wire logic irq_n_in,
    input wire logic auto_in,
    input wire logic [3:0] delay_in,
    input wire logic [15:0] flag_in,
    output var logic [15:0] clr_out
);
    logic [3:0] wait_q = 4'h0;
    initial clr_out = 16'h0000;
    always @(negedge clk_in) begin
        if (!auto_in || irq_n_in) begin
            wait_q <= 4'h0;
            clr_out <= 16'h0000;
        end else if (wait_q == delay_in) begin
            clr_out <= flag_in;
            wait_q <= 4'h0;
        end else begin
            clr_out <= 16'h0000;
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : qbf_host_model
`default_nettype wire

// ===== dv/qbf_fault_irq_chk.sv
// Purpose: Port assertions for the fault interrupt logic.
// Assumes: The irq line trails the flags by one edge.
// Notes: Timing checks wait two edges after reset for outputs to settle.
`timescale 1ns/1ps
`default_nettype none
module qbf_fault_irq_chk #(
    parameter int NCORES = 4
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic irq_out_n,
    input wire logic [NCORES-1:0] core_irq_summary_out,
    input wire logic [NCORES-1:0] core_ilimit_flag_out,
    input wire logic [NCORES-1:0] core_short_flag_out,
    input wire logic [NCORES-1:0] core_pgood_flag_out,
    input wire logic [NCORES-1:0] core_ilimit_mask_in,
    input wire logic [NCORES-1:0] core_pgood_mask_in,
    input wire logic [NCORES-1:0] core_switch_en_out,
    input wire logic overtemp_warn_flag_out,
    input wire logic overtemp_warn_mask_in,
    input wire logic overtemp_warn_live_out,
    input wire logic overtemp_shutdown_flag_out,
    input wire logic load_ready_flag_out,
    input wire logic load_ready_mask_in,
    input wire logic load_ready_clr_in,
    input wire logic load_meas_done_in,
    input wire logic reset_occurred_flag_out,
    input wire logic reset_occurred_mask_in
);
    wire logic pend;
    logic [1:0] up_q;
    assign pend = (|(core_ilimit_flag_out & ~core_ilimit_mask_in)) | (|core_short_flag_out)
        | (|(core_pgood_flag_out & ~core_pgood_mask_in)) | overtemp_shutdown_flag_out
        | (overtemp_warn_flag_out & ~overtemp_warn_mask_in)
        | (load_ready_flag_out & ~load_ready_mask_in)
        | (reset_occurred_flag_out & ~reset_occurred_mask_in);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            up_q <= 2'h0;
        end else if (!up_q[1]) begin
            up_q <= up_q + 2'h1;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    // ==========
    // Assertions
    a_irq_follows_pending:
        assert property (up_q[1] |-> irq_out_n == !$past(pend))
        else $error("irq line wrong");
    a_summary_or:
        assert property (up_q[1] |-> core_irq_summary_out ==
            $past(core_ilimit_flag_out | core_short_flag_out | core_pgood_flag_out))
        else $error("core summary wrong");
    a_reset_flag_set:
        assert property (disable iff (1'b0) srst_in |=>
            reset_occurred_flag_out && core_switch_en_out == '0)
        else $error("reset state wrong");
    a_short_core_off:
        assert property ((core_short_flag_out & $past(core_short_flag_out)
            & core_switch_en_out) == '0)
        else $error("tripped core switching");
    a_shutdown_all_off:
        assert property (overtemp_shutdown_flag_out && $past(overtemp_shutdown_flag_out)
            |-> core_switch_en_out == '0)
        else $error("core on in shutdown");
    a_load_flag_set:
        assert property (load_meas_done_in |=> load_ready_flag_out)
        else $error("load flag not set");
    a_load_clear:
        assert property (load_ready_flag_out && load_ready_clr_in && !load_meas_done_in
            |=> !load_ready_flag_out)
        else $error("load flag not cleared");
    a_warn_hot_kept:
        assert property (overtemp_warn_live_out [*2] |-> overtemp_warn_flag_out)
        else $error("warn flag lost while hot");
    c_irq_low: cover property ($fell(irq_out_n));
    c_short_trip: cover property ($rose(core_short_flag_out[0]));
    c_shutdown: cover property ($rose(overtemp_shutdown_flag_out));
endmodule : qbf_fault_irq_chk
bind qbf_fault_irq qbf_fault_irq_chk #(.NCORES(NCORES)) qbf_fault_irq_chk_inst (
    .clk_in, .srst_in, .irq_out_n, .core_irq_summary_out, .core_ilimit_flag_out,
    .core_short_flag_out, .core_pgood_flag_out, .core_ilimit_mask_in, .core_pgood_mask_in,
    .core_switch_en_out, .overtemp_warn_flag_out, .overtemp_warn_mask_in,
    .overtemp_warn_live_out, .overtemp_shutdown_flag_out, .load_ready_flag_out,
    .load_ready_mask_in, .load_ready_clr_in, .load_meas_done_in, .reset_occurred_flag_out,
    .reset_occurred_mask_in
);
`default_nettype wire

// ===== dv/tb_qbf_fault_irq.sv
// Purpose: Self-checking bench for the fault interrupt logic.
// Assumes: Debounce counts cut to N and L cycles.
// Notes: flg and clr order: ilimit, short, pgood, warn, shutdown, load, reset.
`timescale 1ns/1ps
`default_nettype none
module tb_qbf_fault_irq;
    localparam int N = 4;
    localparam int L = 16;
    logic clk_in = 1'b0;
    logic srst = 1'b1;
    logic [3:0] en, il, uv, pg, ilm, pgm, dly;
    logic tw, ts, tsel, ld, twm, ldm, rsm, au;
    logic [11:0] lsel;
    logic [15:0] wr;
    wire logic [15:0] hc, flg, clr;
    wire logic [11:0] lim;
    wire logic [3:0] sum, ill, run, pgl, sw;
    wire logic irq_n, twl, tsl, thr;
    int err_total = 0;
    int tests_run = 0;
    int cyc_cnt = 0;
    assign clr = wr | hc;
    always #25 clk_in = ~clk_in;
    qbf_fault_irq #(.SHORT_DEB_CYC(N), .LONG_DEB_CYC(L)) qbf_fault_irq_inst (
        .clk_in(clk_in), .srst_in(srst), .core_enable_in(en), .core_current_limit_sel_in(lsel),
        .core_ilimit_raw_in(il), .core_undervolt_raw_in(uv), .core_pgood_raw_in(pg),
        .overtemp_warn_raw_in(tw), .overtemp_shutdown_raw_in(ts),
        .overtemp_warn_threshold_sel_in(tsel), .load_meas_done_in(ld),
        .core_ilimit_mask_in(ilm), .core_pgood_mask_in(pgm), .overtemp_warn_mask_in(twm),
        .load_ready_mask_in(ldm), .reset_occurred_mask_in(rsm), .core_ilimit_clr_in(clr[3:0]),
        .core_short_clr_in(clr[7:4]), .core_pgood_clr_in(clr[11:8]),
        .overtemp_warn_clr_in(clr[12]), .overtemp_shutdown_clr_in(clr[13]),
        .load_ready_clr_in(clr[14]), .reset_occurred_clr_in(clr[15]), .irq_out_n(irq_n),
        .core_irq_summary_out(sum), .core_ilimit_flag_out(flg[3:0]), .core_ilimit_live_out(ill),
        .core_short_flag_out(flg[7:4]), .core_running_status_out(run),
        .core_pgood_flag_out(flg[11:8]), .core_pgood_live_out(pgl),
        .overtemp_warn_flag_out(flg[12]), .overtemp_warn_live_out(twl),
        .overtemp_shutdown_flag_out(flg[13]), .overtemp_shutdown_live_out(tsl),
        .load_ready_flag_out(flg[14]), .reset_occurred_flag_out(flg[15]),
        .core_current_limit_out(lim), .overtemp_warn_threshold_out(thr), .core_switch_en_out(sw)
    );
    qbf_host_model qbf_host_model_inst (.clk_in(clk_in), .irq_n_in(irq_n), .auto_in(au),
        .delay_in(dly), .flag_in(flg), .clr_out(hc));
    // ==========
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    task automatic pulse(input int b);
        wr[b] = 1'b1;
        cyc(1);
        wr[b] = 1'b0;
    endtask : pulse
    task automatic wait_rel();
        for (int k = 0; k < 40 && irq_n !== 1'b1; k++) begin
            cyc(1);
        end
    endtask : wait_rel
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    always @(posedge clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            err_total++;
            close_out();
        end
    end
    // ==========
    // Scenarios
    initial begin
        {en, il, uv, pg, ilm, pgm, dly, tw, ts, tsel, ld, twm, ldm, rsm, au, lsel, wr} = '0;
        cyc(4);
        srst = 1'b0;
        cyc(3);
        chk({flg, irq_n}, 17'h10000, "start-up flag");
        pulse(15);
        cyc(2);
        chk(irq_n, 1, "irq release");
        lsel = 12'hA53;
        tsel = 1'b1;
        cyc(4);
        chk({lim, thr}, {12'hA53, 1'b1}, "limit copy");
        for (int i = 0; i < 4; i++) begin
            il[i] = 1'b1;
            cyc(N + 6);
            chk({flg, ill, sum, irq_n}, {16'h1 << i, 4'h1 << i, 4'h1 << i, 1'b0}, "ilim");
            pulse(i);
            cyc(1);
            chk(flg, 16'h1 << i, "ilim clear refused");
            il[i] = 1'b0;
            cyc(N + 4);
            pulse(i);
            cyc(2);
            chk({flg, irq_n}, 17'h1, "ilim cleared");
        end
        ilm = 4'hF;
        il[2] = 1'b1;
        cyc(2);
        il[2] = 1'b0;
        cyc(N + 6);
        chk(flg, 0, "glitch kept out");
        il[2] = 1'b1;
        cyc(N + 6);
        chk({flg, irq_n}, 17'h9, "masked ilim");
        il[2] = 1'b0;
        ilm = 4'h0;
        cyc(2);
        chk(irq_n, 0, "unmasked ilim");
        cyc(N + 4);
        pulse(2);
        pg = 4'h8;
        cyc(N + 6);
        chk({flg, pgl, sum}, 24'h80088, "pgood");
        pgm = 4'h8;
        cyc(2);
        chk(irq_n, 1, "pgood masked");
        pulse(11);
        cyc(1);
        chk(flg, 0, "pgood clear");
        ld = 1'b1;
        cyc(1);
        ld = 1'b0;
        cyc(4);
        chk(flg, 16'h4000, "load ready kept");
        pulse(14);
        cyc(1);
        chk(flg, 0, "load clear");
        tw = 1'b1;
        cyc(N + 6);
        chk({flg, twl, irq_n}, 18'h4002, "warning");
        pulse(12);
        cyc(1);
        chk(flg, 16'h1000, "warn clear refused");
        twm = 1'b1;
        tw = 1'b0;
        cyc(2);
        chk(irq_n, 1, "warn masked");
        cyc(N + 4);
        pulse(12);
        cyc(1);
        chk(flg, 0, "warn clear");
        {ilm, pgm, twm, ldm, rsm} = '1;
        en = 4'h1;
        pg = 4'h9;
        cyc(N + 6);
        chk({sw, run}, 8'h11, "core on");
        uv = 4'h1;
        cyc(L + 6);
        chk({flg, sw, run, irq_n}, 25'h0022000, "short trip");
        uv = 4'h0;
        cyc(L + 4);
        dly = 4'h5;
        au = 1'b1;
        wait_rel();
        chk(flg, 0, "host clears short");
        cyc(4);
        chk(sw, 4'h1, "core retry");
        dly = 4'h0;
        en = 4'hF;
        cyc(6);
        ts = 1'b1;
        cyc(N + 8);
        chk({flg[13], tsl, sw, irq_n}, 7'h60, "thermal shutdown");
        ts = 1'b0;
        cyc(N + 4);
        wait_rel();
        chk(flg, 0, "shutdown clear");
        cyc(6);
        chk(sw, 4'hF, "cores back");
        au = 1'b0;
        srst = 1'b1;
        cyc(2);
        chk({flg, sw}, 20'h80000, "reset mid-run");
        srst = 1'b0;
        cyc(2);
        close_out();
    end
endmodule : tb_qbf_fault_irq
`default_nettype wire
